// ===== logic/cpcrx_top.sv
// CAN setting registers, two-stage receive path and ASCII transmit buffer
// assumes RX_* come from a CAN controller on CORE_CLK_I; AXI4-Lite slave
// Function
// - error-check byte only for protocols 6..C
// - b7 set requires eight data bytes
// - b6 set rejects zero protocol control byte
// - b2 enables response-pending handling
// - b1 limits pending handling to modes 00..0F
// - b0 limits pending handling to ISO protocols
// - truck rate is 500k over divisor, 01..40
// - user option b7 picks 11 or 29-bit transmit
// - user option b6 picks fixed or variable length
// - b5 clear: receive ID length follows b7
// - user option b4 multiplies rate by 8/7
// - reported rate is base rate from divisor
// - option bits 2..0 pick format, 010 truck
// - first user divisor, default 04
// - second user options, same layout, default 80
// - second user divisor, default 0A
// - settings are binary, shown as hex digits
// - bit 7 msb, bit 0 lsb
// - capture stage feeds a second holding stage
// - check, reply, format ASCII, buffer, then next
// - transmit buffer holds 512 bytes
// - full buffer reports overflow, needs restart
//
// The AXI4-Lite slave port is this design's own decision.
module cpcrx_top #(
   parameter int BUF_DEPTH = 512
) (
   input wire logic CORE_CLK_I,
   input wire logic RESET_N_I,
   input wire logic AWVALID_I,
   output logic AWREADY_O,
   input wire logic [cpcrx_pkg::ADDR_W-1:0] AWADDR_I,
   input wire logic WVALID_I,
   output logic WREADY_O,
   input wire logic [31:0] WDATA_I,
   input wire logic [3:0] WSTRB_I,
   output logic BVALID_O,
   input wire logic BREADY_I,
   output logic [1:0] BRESP_O,
   input wire logic ARVALID_I,
   output logic ARREADY_O,
   input wire logic [cpcrx_pkg::ADDR_W-1:0] ARADDR_I,
   output logic RVALID_O,
   input wire logic RREADY_I,
   output logic [31:0] RDATA_O,
   output logic [1:0] RRESP_O,
   input wire logic RX_VALID_I,
   input wire logic RX_EXT_I,
   input wire logic [28:0] RX_ID_I,
   input wire logic [3:0] RX_DLC_I,
   input wire logic [63:0] RX_DATA_I,
   output logic BIT_TICK_O,
   output logic TX_ID_11B_O,
   output logic VAR_DLC_O,
   output logic TRUCK_FMT_O,
   output logic RSP_PEND_O,
   output logic REPLY_REQ_O,
   output logic BUF_FULL_O
);
   import cpcrx_pkg::*;
   localparam int PW = $clog2(BUF_DEPTH);
   if (BUF_DEPTH < 64 || BUF_DEPTH > 512 || (1 << PW) != BUF_DEPTH) begin : g_chk
      $error("BUF_DEPTH must be a power of two, 64..512");
   end

   function automatic logic [7:0] hex_ch(input logic [3:0] n);
      hex_ch = (n < 4'hA) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
   endfunction

   function automatic logic [7:0] clamp_div(input logic [7:0] d);
      clamp_div = (d < DIV_MIN) ? DIV_MIN : (d > DIV_MAX) ? DIV_MAX : d;
   endfunction

   function automatic logic [7:0] adr(input logic [7:0] idx);
      adr = {idx[5:0], 2'b00};
   endfunction

   // one output character per index: ID digits, then " HH" per byte, then CR
   function automatic logic [7:0] char_at(input logic [5:0] ci, input logic ext,
         input logic [28:0] id, input logic [63:0] d, input logic [3:0] n);
      logic [5:0] idd, j, q;
      logic [31:0] idw;
      logic [7:0] b;
      idd = ext ? 6'd8 : 6'd3;
      idw = {3'b000, id};
      char_at = CHR_CR;
      b = 8'h00;
      if (ci < idd) begin
         char_at = hex_ch(idw[(idd - ci - 6'd1) * 4 +: 4]);
      end else begin
         j = ci - idd;
         q = j / 6'd3;
         if (q < {2'b00, n}) begin
            b = d[(6'd7 - q) * 8 +: 8];
            case (j % 6'd3)
               6'd0: char_at = CHR_SP;
               6'd1: char_at = hex_ch(b[7:4]);
               default: char_at = hex_ch(b[3:0]);
            endcase
         end
      end
   endfunction

   logic rq1_r, rst_n;
   always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         rq1_r <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rq1_r <= 1'b1;
         rst_n <= rq1_r;
      end
   end

   // register bus group
   logic awa_r, awa_nxt, wa_r, wa_nxt, bv_r, bv_nxt, rv_r, rv_nxt;
   logic [7:0] awad_r, awad_nxt;
   logic [31:0] wd_r, wd_nxt, rd_r, rd_nxt;
   logic [3:0] ws_r, ws_nxt;
   logic [1:0] br_r, br_nxt, rr_r, rr_nxt;
   logic [7:0] ec_r, ec_nxt, td_r, td_nxt, o1_r, o1_nxt, d1_r, d1_nxt;
   logic [7:0] o2_r, o2_nxt, d2_r, d2_nxt;
   logic [3:0] pr_r, pr_nxt;
   logic do_wr, restart, pop;
   logic [PW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
   logic [PW:0] cnt_r, cnt_nxt;
   logic [7:0] mem [BUF_DEPTH];
   logic push, full;
   logic [7:0] pch;
   logic ovf_r, ovf_nxt, ovr_r, ovr_nxt;
   logic [8:0] rate;
   logic [7:0] dsel;

   assign do_wr = awa_r && wa_r && !bv_r;
   assign restart = do_wr && awad_r == adr(IDX_CTRL) && ws_r[1] && wd_r[CT_RESTART];
   assign pop = ARVALID_I && !rv_r && ARADDR_I == adr(IDX_TXDAT) && cnt_r != '0;

   always_comb begin
      awa_nxt = awa_r;
      wa_nxt = wa_r;
      awad_nxt = awad_r;
      wd_nxt = wd_r;
      ws_nxt = ws_r;
      bv_nxt = bv_r && !BREADY_I;
      br_nxt = br_r;
      rv_nxt = rv_r && !RREADY_I;
      rd_nxt = rd_r;
      rr_nxt = rr_r;
      {ec_nxt, td_nxt, o1_nxt, d1_nxt, o2_nxt, d2_nxt} = {ec_r, td_r, o1_r, d1_r, o2_r, d2_r};
      pr_nxt = pr_r;
      if (AWVALID_I && AWREADY_O) begin
         awa_nxt = 1'b1;
         awad_nxt = AWADDR_I;
      end
      if (WVALID_I && WREADY_O) begin
         wa_nxt = 1'b1;
         wd_nxt = WDATA_I;
         ws_nxt = WSTRB_I;
      end
      if (do_wr) begin
         awa_nxt = 1'b0;
         wa_nxt = 1'b0;
         bv_nxt = 1'b1;
         br_nxt = RESP_OK;
         case (awad_r)
            adr(IDX_ERRCHK): if (ws_r[0]) ec_nxt = wd_r[7:0];
            adr(IDX_TRKDIV): if (ws_r[0]) td_nxt = wd_r[7:0];
            adr(IDX_OPT1): if (ws_r[0]) o1_nxt = wd_r[7:0];
            adr(IDX_DIV1): if (ws_r[0]) d1_nxt = wd_r[7:0];
            adr(IDX_OPT2): if (ws_r[0]) o2_nxt = wd_r[7:0];
            adr(IDX_DIV2): if (ws_r[0]) d2_nxt = wd_r[7:0];
            adr(IDX_CTRL): if (ws_r[0]) pr_nxt = wd_r[3:0];
            adr(IDX_STAT), adr(IDX_TXDAT): br_nxt = RESP_OK;
            default: br_nxt = RESP_DEC;
         endcase
      end
      if (ARVALID_I && ARREADY_O) begin
         rv_nxt = 1'b1;
         rr_nxt = RESP_OK;
         rd_nxt = 32'h0000_0000;
         case (ARADDR_I)
            adr(IDX_ERRCHK): rd_nxt[7:0] = ec_r;
            adr(IDX_TRKDIV): rd_nxt[7:0] = td_r;
            adr(IDX_OPT1): rd_nxt[7:0] = o1_r;
            adr(IDX_DIV1): rd_nxt[7:0] = d1_r;
            adr(IDX_OPT2): rd_nxt[7:0] = o2_r;
            adr(IDX_DIV2): rd_nxt[7:0] = d2_r;
            adr(IDX_CTRL): rd_nxt[3:0] = pr_r;
            adr(IDX_STAT): begin
               rd_nxt[9:0] = 10'(cnt_r);
               rd_nxt[ST_OVF] = ovf_r;
               rd_nxt[ST_OVR] = ovr_r;
               rd_nxt[ST_RATE +: 9] = rate;
            end
            adr(IDX_TXDAT): begin
               rd_nxt[7:0] = (cnt_r != '0) ? mem[rp_r] : 8'h00;
               rd_nxt[TX_VALID] = cnt_r != '0;
            end
            default: rr_nxt = RESP_DEC;
         endcase
      end
   end

   always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         {awa_r, wa_r, bv_r, rv_r} <= 4'h0;
         awad_r <= 8'h00;
         wd_r <= 32'h0000_0000;
         ws_r <= 4'h0;
         br_r <= RESP_OK;
         rr_r <= RESP_OK;
         rd_r <= 32'h0000_0000;
         ec_r <= RST_ERRCHK;
         td_r <= RST_TRKDIV;
         o1_r <= RST_OPT1;
         d1_r <= RST_DIV1;
         o2_r <= RST_OPT2;
         d2_r <= RST_DIV2;
         pr_r <= RST_PROTO;
      end else begin
         {awa_r, wa_r, bv_r, rv_r} <= {awa_nxt, wa_nxt, bv_nxt, rv_nxt};
         awad_r <= awad_nxt;
         wd_r <= wd_nxt;
         ws_r <= ws_nxt;
         br_r <= br_nxt;
         rr_r <= rr_nxt;
         rd_r <= rd_nxt;
         {ec_r, td_r, o1_r, d1_r, o2_r, d2_r} <= {ec_nxt, td_nxt, o1_nxt, d1_nxt, o2_nxt, d2_nxt};
         pr_r <= pr_nxt;
      end
   end

   assign AWREADY_O = !awa_r && !bv_r;
   assign WREADY_O = !wa_r && !bv_r;
   assign ARREADY_O = !rv_r;
   assign BVALID_O = bv_r;
   assign BRESP_O = br_r;
   assign RVALID_O = rv_r;
   assign RDATA_O = rd_r;
   assign RRESP_O = rr_r;

   // active protocol decode
   logic is_can, is_iso, is_user;
   logic [7:0] opt;
   assign is_can = pr_r >= P_FIRST && pr_r <= P_SECOND_CUSTOM_CAN_PROTOCOL;
   assign is_iso = pr_r >= P_FIRST && pr_r <= P_ISOLAST;
   assign is_user = pr_r == P_FIRST_CUSTOM_CAN_PROTOCOL || pr_r == P_SECOND_CUSTOM_CAN_PROTOCOL;
   // reserved option bit 3 is never looked at
   assign opt = (pr_r == P_SECOND_CUSTOM_CAN_PROTOCOL) ? o2_r : o1_r;
   assign dsel = clamp_div((pr_r == P_FIRST_CUSTOM_CAN_PROTOCOL) ? d1_r : (pr_r == P_SECOND_CUSTOM_CAN_PROTOCOL) ? d2_r : td_r);
   // reported rate ignores the 8/7 multiplier
   assign rate = 9'(BASE_KBPS / int'(dsel));
   assign TX_ID_11B_O = is_user && opt[OP_TX11];
   assign VAR_DLC_O = is_user && opt[OP_VDLC];
   assign TRUCK_FMT_O = pr_r == P_TRUCK || (is_user && opt[2:0] == FMT_TRUCK);

   cpcrx_baud #(.UNIT_CYC(BASE_CYC)) u_baud (
      .clk_i(CORE_CLK_I),
      .rst_n_i(rst_n),
      .div_i(dsel),
      .fast_i(is_user && opt[OP_FAST]),
      .tick_o(BIT_TICK_O)
   );

   // receive stages and frame processing
   cpcrx_state_e st_r, st_nxt;
   logic s1v_r, s1v_nxt, s2v_r, s2v_nxt, pend_r, pend_nxt, rep_r, rep_nxt;
   logic [FR_W-1:0] s1_r, s1_nxt, s2_r, s2_nxt;
   logic [5:0] ci_r, ci_nxt, total;
   logic move1, f_ext, ok, pend_c, rep_c;
   logic [28:0] f_id;
   logic [3:0] f_dlc, f_n;
   logic [63:0] f_d;
   logic [7:0] by0, by1, by2, by3;

   assign {f_ext, f_id, f_dlc, f_d} = s2_r;
   assign {by0, by1, by2, by3} = f_d[63:32];
   assign f_n = (f_dlc > 4'd8) ? 4'd8 : f_dlc;
   assign total = (f_ext ? 6'd8 : 6'd3) + 6'd3 * {2'b00, f_n} + 6'd1;
   assign move1 = s1v_r && !s2v_r;
   assign full = cnt_r[PW];

   always_comb begin
      ok = 1'b1;
      if (is_can && ec_r[EC_LEN8] && f_dlc != 4'd8) ok = 1'b0;
      if (is_can && ec_r[EC_PCI0] && by0 == 8'h00) ok = 1'b0;
      if (is_user && !opt[OP_VDLC] && f_dlc != 4'd8) ok = 1'b0;
      if (is_user && !opt[OP_RXANY] && f_ext == opt[OP_TX11]) ok = 1'b0;
      pend_c = is_can && ec_r[EC_PEND] && f_n >= 4'd4
         && by1 == NEG_RSP && by3 == RSP_PEND
         && (!ec_r[EC_MODE] || by2 <= MODE_MAX)
         && (!ec_r[EC_ISO] || is_iso);
      rep_c = is_iso && by0[7:4] == 4'h1;
   end

   always_comb begin
      st_nxt = st_r;
      s1v_nxt = s1v_r;
      s1_nxt = s1_r;
      s2v_nxt = s2v_r;
      s2_nxt = s2_r;
      ci_nxt = ci_r;
      pend_nxt = 1'b0;
      rep_nxt = 1'b0;
      ovf_nxt = ovf_r && !restart;
      ovr_nxt = ovr_r && !restart;
      push = 1'b0;
      pch = char_at(ci_r, f_ext, f_id, f_d, f_n);
      if (move1) begin
         s2v_nxt = 1'b1;
         s2_nxt = s1_r;
         s1v_nxt = 1'b0;
      end
      if (RX_VALID_I) begin
         if (!s1v_r || move1) begin
            s1v_nxt = 1'b1;
            s1_nxt = {RX_EXT_I, RX_ID_I, RX_DLC_I, RX_DATA_I};
         end else begin
            ovr_nxt = 1'b1;
         end
      end
      case (st_r)
         ST_IDLE: if (s2v_r) st_nxt = ST_CHECK;
         ST_CHECK: begin
            if (ok) begin
               pend_nxt = pend_c;
               st_nxt = ST_REPLY;
            end else begin
               s2v_nxt = 1'b0;
               st_nxt = ST_IDLE;
            end
         end
         ST_REPLY: begin
            rep_nxt = rep_c;
            ci_nxt = 6'd0;
            st_nxt = ST_EMIT;
         end
         ST_EMIT: begin
            if (full) begin
               ovf_nxt = 1'b1;
               s2v_nxt = 1'b0;
               st_nxt = ST_HALT;
            end else begin
               push = 1'b1;
               ci_nxt = ci_r + 6'd1;
               if (ci_r == total - 6'd1) begin
                  s2v_nxt = 1'b0;
                  st_nxt = ST_IDLE;
               end
            end
         end
         ST_HALT: begin
            // frames are dropped until software restarts
            s2v_nxt = 1'b0;
            if (restart) begin
               s1v_nxt = 1'b0;
               st_nxt = ST_IDLE;
            end
         end
         default: st_nxt = ST_IDLE;
      endcase
   end

   always_comb begin
      wp_nxt = push ? wp_r + 1'b1 : wp_r;
      rp_nxt = pop ? rp_r + 1'b1 : rp_r;
      cnt_nxt = cnt_r + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
   end

   always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= ST_IDLE;
         {s1v_r, s2v_r, pend_r, rep_r, ovf_r, ovr_r} <= 6'h00;
         s1_r <= '0;
         s2_r <= '0;
         ci_r <= 6'd0;
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
      end else begin
         st_r <= st_nxt;
         {s1v_r, s2v_r, pend_r, rep_r} <= {s1v_nxt, s2v_nxt, pend_nxt, rep_nxt};
         {ovf_r, ovr_r} <= {ovf_nxt, ovr_nxt};
         s1_r <= s1_nxt;
         s2_r <= s2_nxt;
         ci_r <= ci_nxt;
         wp_r <= wp_nxt;
         rp_r <= rp_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   // storage has no reset; only written slots are ever read
   always_ff @(posedge CORE_CLK_I) begin
      if (push) mem[wp_r] <= pch;
   end

   assign RSP_PEND_O = pend_r;
   assign REPLY_REQ_O = rep_r;
   assign BUF_FULL_O = ovf_r;

   default clocking cb @(posedge CORE_CLK_I); endclocking
   default disable iff (!rst_n);

   sequence s_frame_waits;
      s1v_r && !s2v_r && st_r == ST_IDLE;
   endsequence
   sequence s_taken;
      s2v_r ##1 st_r == ST_CHECK;
   endsequence

   a_stage_handoff: assert property (s_frame_waits |=> s_taken)
      else $error("second stage not loaded from first");
   a_rx_overrun: assert property (RX_VALID_I && s1v_r && s2v_r |=> ovr_r)
      else $error("overrun not flagged");
   a_len_reject: assert property (st_r == ST_CHECK && is_can && ec_r[EC_LEN8]
      && f_dlc != 4'd8 |=> st_r == ST_IDLE && !RSP_PEND_O)
      else $error("short frame not rejected");
   a_pci_reject: assert property (st_r == ST_CHECK && is_can && ec_r[EC_PCI0]
      && by0 == 8'h00 |=> st_r == ST_IDLE ##1 st_r != ST_EMIT)
      else $error("zero control byte not rejected");
   a_pend_flag: assert property (st_r == ST_CHECK && ok && pend_c
      |=> RSP_PEND_O ##1 !RSP_PEND_O)
      else $error("pending reply not flagged once");
   a_pend_mode: assert property (st_r == ST_CHECK && ec_r[EC_MODE]
      && by2 > MODE_MAX |=> !RSP_PEND_O)
      else $error("pending flagged for high mode");
   a_pend_iso: assert property (st_r == ST_CHECK && ec_r[EC_ISO] && !is_iso |=> !RSP_PEND_O)
      else $error("pending flagged outside iso protocols");
   a_ovf_sticky: assert property (ovf_r && !restart |=> ovf_r)
      else $error("overflow flag lost");
   a_full_halt: assert property (st_r == ST_EMIT && full |=> ovf_r && st_r == ST_HALT
      && cnt_r == $past(cnt_r) - {{PW{1'b0}}, $past(pop)})
      else $error("full buffer did not halt");
   a_line_end: assert property (push && ci_r == total - 6'd1 |-> pch == CHR_CR
      ##1 st_r == ST_IDLE)
      else $error("line not closed by CR");
   a_bresp_hold: assert property (BVALID_O && !BREADY_I |=> BVALID_O && $stable(BRESP_O))
      else $error("write response dropped");
endmodule

// ===== logic/cpcrx_pkg.sv
// constants shared by the CAN setting registers, receive path and bit-rate divider
// assumes a single 50 MHz core clock
package cpcrx_pkg;
   localparam int CLK_HZ = 50_000_000;
   localparam int BASE_KBPS = 500;
   // clock cycles per divisor unit of the base bit rate
   localparam int BASE_CYC = CLK_HZ / (BASE_KBPS * 1000);
   localparam int MUL_NUM = 8;
   localparam int MUL_DEN = 7;
   localparam int ADDR_W = 8;
   // printed setting indices; byte address is four times the index
   localparam logic [7:0] IDX_ERRCHK = 8'h2A;
   localparam logic [7:0] IDX_TRKDIV = 8'h2B;
   localparam logic [7:0] IDX_OPT1 = 8'h2C;
   localparam logic [7:0] IDX_DIV1 = 8'h2D;
   localparam logic [7:0] IDX_OPT2 = 8'h2E;
   localparam logic [7:0] IDX_DIV2 = 8'h2F;
   localparam logic [7:0] IDX_CTRL = 8'h00;
   localparam logic [7:0] IDX_STAT = 8'h01;
   localparam logic [7:0] IDX_TXDAT = 8'h02;
   localparam logic [7:0] RST_ERRCHK = 8'h3C;
   localparam logic [7:0] RST_TRKDIV = 8'h02;
   localparam logic [7:0] RST_OPT1 = 8'hE0;
   localparam logic [7:0] RST_DIV1 = 8'h04;
   localparam logic [7:0] RST_OPT2 = 8'h80;
   localparam logic [7:0] RST_DIV2 = 8'h0A;
   localparam logic [3:0] RST_PROTO = 4'h6;
   localparam logic [7:0] DIV_MIN = 8'h01;
   localparam logic [7:0] DIV_MAX = 8'h40;
   // bit positions, b7 msb .. b0 lsb
   localparam int EC_LEN8 = 7;
   localparam int EC_PCI0 = 6;
   localparam int EC_PEND = 2;
   localparam int EC_MODE = 1;
   localparam int EC_ISO = 0;
   localparam int OP_TX11 = 7;
   localparam int OP_VDLC = 6;
   localparam int OP_RXANY = 5;
   localparam int OP_FAST = 4;
   localparam logic [2:0] FMT_TRUCK = 3'b010;
   localparam int CT_RESTART = 8;
   localparam int ST_OVF = 12;
   localparam int ST_OVR = 13;
   localparam int ST_RATE = 16;
   localparam int TX_VALID = 8;
   localparam logic [3:0] P_FIRST = 4'h6;
   localparam logic [3:0] P_ISOLAST = 4'h9;
   localparam logic [3:0] P_TRUCK = 4'hA;
   localparam logic [3:0] P_FIRST_CUSTOM_CAN_PROTOCOL = 4'hB;
   localparam logic [3:0] P_SECOND_CUSTOM_CAN_PROTOCOL = 4'hC;
   localparam logic [7:0] NEG_RSP = 8'h7F;
   localparam logic [7:0] RSP_PEND = 8'h78;
   localparam logic [7:0] MODE_MAX = 8'h0F;
   localparam logic [7:0] CHR_CR = 8'h0D;
   localparam logic [7:0] CHR_SP = 8'h20;
   localparam logic [1:0] RESP_OK = 2'b00;
   localparam logic [1:0] RESP_DEC = 2'b11;
   localparam int FR_W = 98;
   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_CHECK = 5'h02,
      ST_REPLY = 5'h04,
      ST_EMIT = 5'h08,
      ST_HALT = 5'h10
   } cpcrx_state_e;
endpackage

// ===== logic/cpcrx_baud.sv
// CAN bit-rate enable: 500 kbps / divisor, optionally times 8/7
// assumes a divisor already held in 01..40 by the caller
module cpcrx_baud #(
   parameter int UNIT_CYC = cpcrx_pkg::BASE_CYC
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [7:0] div_i,
   input wire logic fast_i,
   output logic tick_o
);
   import cpcrx_pkg::*;
   if (UNIT_CYC < 1 || UNIT_CYC * MUL_DEN * 64 > 65535) begin : g_chk
      $error("UNIT_CYC out of range");
   end
   logic [15:0] acc_r, acc_nxt, lim;
   logic [3:0] step;
   logic tick_r, tick_nxt;
   // fractional accumulator: step 7 gives the base rate, step 8 gives 8/7
   always_comb begin
      step = fast_i ? 4'(MUL_NUM) : 4'(MUL_DEN);
      lim = 16'(UNIT_CYC * MUL_DEN) * {8'h00, div_i};
      acc_nxt = acc_r + {12'h000, step};
      tick_nxt = 1'b0;
      if (acc_r >= lim) begin
         // divisor just shrank; restart the bit
         acc_nxt = 16'h0000;
      end else if (acc_nxt >= lim) begin
         acc_nxt = acc_nxt - lim;
         tick_nxt = 1'b1;
      end
   end
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         acc_r <= 16'h0000;
         tick_r <= 1'b0;
      end else begin
         acc_r <= acc_nxt;
         tick_r <= tick_nxt;
      end
   end
   assign tick_o = tick_r;
endmodule

// ===== verif/cpcrx_can_node.sv
// behavioural CAN node that hands received frames to the receive port
// assumes callers enter send just after a rising clock edge
module cpcrx_can_node (
   input wire logic clk_i,
   output logic rx_valid_o,
   output logic rx_ext_o,
   output logic [28:0] rx_id_o,
   output logic [3:0] rx_dlc_o,
   output logic [63:0] rx_data_o
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      rx_valid_o = 1'b0;
      rx_ext_o = 1'b0;
      rx_id_o = '0;
      rx_dlc_o = '0;
      rx_data_o = '0;
   end
   // n copies back to back; lines scrambled afterwards so stale data never looks valid
   task automatic send(input int n, input logic ext, input logic [28:0] id,
         input logic [3:0] dlc, input logic [63:0] d);
      rx_valid_o <= 1'b1;
      rx_ext_o <= ext;
      rx_id_o <= id;
      rx_dlc_o <= dlc;
      rx_data_o <= d;
      repeat (n) @(posedge clk_i);
      rx_valid_o <= 1'b0;
      rx_ext_o <= ~ext;
      rx_id_o <= ~id;
      rx_dlc_o <= ~dlc;
      rx_data_o <= ~d;
   endtask
endmodule

// ===== verif/can_protocol_config_and_rx_path_test.sv
// self-checking bench for the CAN setting registers and receive path
// assumes an AXI4-Lite master on a 50 MHz clock and a 64-byte buffer
module can_protocol_config_and_rx_path_test;
   timeunit 1ns;
   timeprecision 1ns;
   import cpcrx_pkg::*;
   localparam logic [63:0] FR = 64'h107F227800000000;
   logic clk, rst_n, awv, awr, wv, wrd, bv, br, arv, arr, rv, rr;
   logic [7:0] awa, ara;
   logic [31:0] wd, rdat, v;
   logic [3:0] ws;
   logic [1:0] bresp, rresp, r;
   logic rxv, rxe, tick, id11, vdlc, tfmt, pend, reply, full;
   logic [28:0] rxid;
   logic [3:0] rxdlc;
   logic [63:0] rxd;
   int miscompares, tests_run, pend_n, reply_n, n0;
   logic [7:0] dflt [6] = '{8'h3C, 8'h02, 8'hE0, 8'h04, 8'h80, 8'h0A};
   string ln = "7E8 10 7F 22 78 00 00 00 00";

   cpcrx_top #(.BUF_DEPTH(64)) DUT (.CORE_CLK_I(clk), .RESET_N_I(rst_n),
      .AWVALID_I(awv), .AWREADY_O(awr), .AWADDR_I(awa), .WVALID_I(wv),
      .WREADY_O(wrd), .WDATA_I(wd), .WSTRB_I(ws), .BVALID_O(bv), .BREADY_I(br),
      .BRESP_O(bresp), .ARVALID_I(arv), .ARREADY_O(arr), .ARADDR_I(ara),
      .RVALID_O(rv), .RREADY_I(rr), .RDATA_O(rdat), .RRESP_O(rresp),
      .RX_VALID_I(rxv), .RX_EXT_I(rxe), .RX_ID_I(rxid), .RX_DLC_I(rxdlc),
      .RX_DATA_I(rxd), .BIT_TICK_O(tick), .TX_ID_11B_O(id11), .VAR_DLC_O(vdlc),
      .TRUCK_FMT_O(tfmt), .RSP_PEND_O(pend), .REPLY_REQ_O(reply), .BUF_FULL_O(full));
   cpcrx_can_node node (.clk_i(clk), .rx_valid_o(rxv), .rx_ext_o(rxe),
      .rx_id_o(rxid), .rx_dlc_o(rxdlc), .rx_data_o(rxd));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // pulses counted mid-cycle, clear of the launching edge
   always @(negedge clk) begin
      if (pend === 1'b1) pend_n++;
      if (reply === 1'b1) reply_n++;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test;
      $display("checks %0d, mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // readies and answers taken at the rising edge that samples them; only the watchdog ends a wait
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic bh;
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      bh = 1'b0;
      while (!bh) begin
         @(posedge clk);
         if (awv && awr) awv <= 1'b0;
         if (wv && wrd) wv <= 1'b0;
         bh = (bv === 1'b1);
         r = bresp;
      end
   endtask
   task automatic rd(input logic [7:0] a);
      logic rh;
      ara <= a;
      arv <= 1'b1;
      rh = 1'b0;
      while (!rh) begin
         @(posedge clk);
         if (arv && arr) arv <= 1'b0;
         rh = (rv === 1'b1);
         v = rdat;
         r = rresp;
      end
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      rd(a);
      chk(v & m, e);
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clk);
   endtask

   initial begin
      #400_000;
      miscompares++;
      end_of_test;
   end

   initial begin
      rst_n = 1'b0;
      {awv, wv, arv} = 3'b000;
      {br, rr} = 2'b11;
      ws = 4'hF;
      {awa, ara, wd} = '0;
      {miscompares, tests_run, pend_n, reply_n} = '0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      idle(4);
      foreach (dflt[i]) begin
         rd(8'hA8 + 8'(4 * i));
         chk(v, {24'h0, dflt[i]});
      end
      rdchk(8'h04, 32'h01FF0000, 32'd250 << 16);
      rd(8'h40);
      chk(32'(r), 32'(RESP_DEC));
      wr(8'h44, 32'h0);
      chk(32'(r), 32'(RESP_DEC));
      node.send(1, 1'b0, 29'h7E8, 4'h8, FR);
      idle(60);
      chk(32'(pend_n), 1);
      chk(32'(reply_n), 1);
      rdchk(8'h04, 32'h3FF, 28);
      for (int i = 0; i <= ln.len(); i++) begin
         rd(8'h08);
         chk(v, {23'h0, 1'b1, (i < ln.len()) ? 8'(ln[i]) : CHR_CR});
      end
      rdchk(8'h08, 32'h100, 0);
      wr(8'hA8, 32'h3E);
      node.send(1, 1'b0, 29'h7E8, 4'h8, FR);
      idle(60);
      chk(32'(pend_n), 1);
      rdchk(8'h04, 32'h3FF, 28);
      wr(8'hA8, 32'hBC);
      node.send(1, 1'b0, 29'h7E8, 4'h4, FR);
      idle(60);
      rdchk(8'h04, 32'h3FF, 28);
      wr(8'hA8, 32'h7C);
      node.send(1, 1'b0, 29'h7E8, 4'h8, {8'h00, FR[55:0]});
      idle(60);
      rdchk(8'h04, 32'h3FF, 28);
      wr(8'hA8, 32'h3C);
      // third frame meets both stages full; second cannot fit the buffer
      node.send(3, 1'b0, 29'h7E8, 4'h8, FR);
      idle(100);
      rdchk(8'h04, 32'h3000, 32'h3000);
      chk(32'(full), 1);
      wr(8'h00, 32'h106);
      rdchk(8'h04, 32'h3000, 0);
      chk(32'(full), 0);
      for (int k = 0; k < 80; k++) rd(8'h08);
      wr(8'h00, 32'h0B);
      chk(32'({id11, vdlc, tfmt}), 3'b110);
      wr(8'hB0, 32'h12);
      wr(8'hB4, 32'h06);
      chk(32'({id11, vdlc, tfmt}), 3'b001);
      rdchk(8'h04, 32'h01FF0000, 32'd83 << 16);
      repeat (2) begin
         n0 = 0;
         do begin
            @(negedge clk);
            n0++;
         end while (tick !== 1'b1 && n0 < 2000);
      end
      chk(32'(n0), BASE_CYC * 6 * MUL_DEN / MUL_NUM);
      @(posedge clk);
      node.send(1, 1'b0, 29'h123, 4'h8, FR);
      idle(60);
      rdchk(8'h04, 32'h3FF, 0);
      // pending handling limited to iso protocols; user protocol must not flag it
      wr(8'hA8, 32'h3D);
      node.send(1, 1'b1, 29'h0ABCDEF0, 4'h8, FR);
      idle(60);
      rdchk(8'h04, 32'h3FF, 33);
      chk(32'(pend_n), 3);
      wr(8'h00, 32'h0C);
      chk(32'({id11, vdlc, tfmt}), 3'b100);
      rdchk(8'h04, 32'h01FF0000, 32'd50 << 16);
      end_of_test;
   end
endmodule
